// >>> hw/report_consts.vh
`ifndef REPORT_CONSTS_VH
`define REPORT_CONSTS_VH
`define OP_REPORT_ID      8'ha3
`define SA_REPORT_ID      5'h05
`define SA_MASK           8'h1f
`define OP_REPORT_UNITS   8'ha0
`define CDB_BYTES         12
`define CDB_IDX_W         4
`define CDB_OP            4'h0
`define CDB_SA            4'h1
`define CDB_LUN_HI        4'h4
`define CDB_LUN_LO        4'h5
`define CDB_ALLOC0        4'h6
`define CDB_ALLOC1        4'h7
`define CDB_ALLOC2        4'h8
`define CDB_ALLOC3        4'h9
`define CDB_LAST          4'hb
`define HDR_BYTES         32'h0000_0004
`define UNIT_LIST_BYTES   32'h0000_0010
`define UNIT_LIST_LEN     8'h08
`define UNIT_LEN_POS      32'h0000_0003
`define STATUS_GOOD       8'h00
`define STATUS_CHECK      8'h02
`define KEY_NONE          4'h0
`define KEY_NOT_READY     4'h2
`define KEY_ILLEGAL       4'h5
`define ASC_NONE          8'h00
`define ASC_INVALID_CDB   8'h24
`define ASC_NOT_READY     8'h04
`define ASCQ_NOT_READY    8'h00
`endif

// >>> hw/skid_buffer.v
`timescale 1ns/1ps
// ****************************************
// Two-entry buffer
// ****************************************
module skid_buffer #(
  parameter WIDTH = 9
) (
  input  wire             clock_in,  // System clock.
  input  wire             rst_n_in,  // Asynchronous reset, active low.
  input  wire [WIDTH-1:0] s_data_in, // Incoming word.
  input  wire             s_valid_in, // Incoming word valid.
  output wire             s_ready_out, // Space for a word.
  output wire [WIDTH-1:0] m_data_out, // Outgoing word.
  output wire             m_valid_out, // Outgoing word valid.
  input  wire             m_ready_in  // Receiver takes the word.
);
  reg [WIDTH-1:0] mem [0:1];
  reg             wr_ptr;
  reg             rd_ptr;
  reg [1:0]       count;
  wire            push;
  wire            pop;

  assign s_ready_out = (count != 2'h2);
  assign m_valid_out = (count != 2'h0);
  assign m_data_out  = mem[rd_ptr];
  assign push        = s_valid_in & s_ready_out;
  assign pop         = m_valid_out & m_ready_in;

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
      mem[0] <= {WIDTH{1'b0}};
      mem[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= s_data_in;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule // skid_buffer

// >>> hw/report_cmd.v
// Function
// [RQ1] Identifier report is opcode A3h, action 05h.
// [RQ2] Nonzero unit field gives illegal request.
// [RQ3] Short allocation truncates identifier data, no error.
// [RQ4] Data: big-endian length then identifier bytes.
// [RQ5] Length field reports full untruncated length.
// [RQ6] Length starts zero; changes only on set.
// [RQ7] Identifier comes from retained store, last set.
// [RQ8] Same identifier returned on every port.
// [RQ9] Store not ready ends with not ready.
// [RQ10] Unit list is opcode A0h, allocation bytes 6-9.
// [RQ11] Unit list runs regardless of reservations.
// [RQ12] Allocation below sixteen gives illegal request.
// [RQ13] Return only whole unit entries that fit.
// [RQ14] Unit data: length 8, reserved, entry.
// [RQ15] Only unit zero exists and is reported.
// [RQ16] Successful transfer ends with good status.
`timescale 1ns/1ps
`include "report_consts.vh"
module report_cmd #(
  parameter ID_MAX   = 64,
  parameter ID_IDX_W = 6
) (
  input  wire                clock_in,      // System clock, 200 MHz.
  input  wire                rst_n_in,      // Asynchronous reset, active low.
  input  wire [7:0]          cdb_byte_in,   // Command descriptor byte.
  input  wire                cdb_valid_in,  // Descriptor byte valid.
  output reg                 cdb_ready_out, // Ready for descriptor bytes.
  input  wire                store_ready_in, // Identifier store ready, level.
  input  wire [31:0]         id_len_in,     // Stored identifier length.
  output reg  [ID_IDX_W-1:0] id_addr_out,   // Identifier byte index.
  input  wire [7:0]          id_byte_in,    // Identifier byte at index.
  output reg  [7:0]          data_out,      // Parameter data byte.
  output reg                 data_last_out, // Last data byte.
  output reg                 data_valid_out, // Data byte valid.
  input  wire                data_ready_in, // Receiver takes byte.
  output reg                 done_out,      // Command complete pulse.
  output reg  [7:0]          status_out,    // Completion status.
  output reg  [3:0]          sense_key_out, // Sense key.
  output reg  [7:0]          asc_out,       // Additional sense code.
  output reg  [7:0]          ascq_out       // Additional sense qualifier.
);
  // ****************************************
  // Descriptor capture and decode
  // ****************************************
  localparam S_CDB  = 3'h0;
  localparam S_DEC  = 3'h1;
  localparam S_SEND = 3'h2;
  localparam S_WAIT = 3'h3;
  localparam S_DONE = 3'h4;

  reg  [2:0]            state;
  reg  [7:0]            cdb [0:`CDB_BYTES-1];
  reg  [`CDB_IDX_W-1:0] cdb_idx;
  reg                   is_units;
  reg  [31:0]           xfer_len;
  reg  [31:0]           pos;
  reg  [31:0]           id_len;
  reg  [7:0]            pend_status;
  reg  [3:0]            pend_key;
  reg  [7:0]            pend_asc;
  reg  [7:0]            pend_ascq;
  wire [31:0]           next_pos;
  wire [31:0]           id_index;
  wire [31:0]           alloc_len;
  wire                  buf_ready;
  wire [8:0]            buf_word;
  wire                  buf_valid;
  reg  [7:0]            next_byte;
  wire                  is_id_cmd;
  wire                  is_units_cmd;
  wire                  lun_nonzero;
  reg                   store_s1;
  reg                   store_s2;
  reg                   store_s3;
  reg                   store_ok;

  assign alloc_len = {cdb[`CDB_ALLOC0], cdb[`CDB_ALLOC1],
                      cdb[`CDB_ALLOC2], cdb[`CDB_ALLOC3]}; // RQ10
  assign is_id_cmd = (cdb[`CDB_OP] == `OP_REPORT_ID) &&
                     ((cdb[`CDB_SA] & `SA_MASK) == {3'h0, `SA_REPORT_ID}); // RQ1
  assign is_units_cmd = (cdb[`CDB_OP] == `OP_REPORT_UNITS); // RQ10
  assign lun_nonzero  = (cdb[`CDB_LUN_HI] != 8'h00) || (cdb[`CDB_LUN_LO] != 8'h00);
  // The store address is set up one cycle ahead from the position that the
  // buffer will hold next, so a stall never shifts the identifier bytes.
  assign next_pos = buf_ready ? (pos + 32'h1) : pos;
  assign id_index = next_pos - `HDR_BYTES;

  function [31:0] min32;
    input [31:0] a;
    input [31:0] b;
    begin
      min32 = (a < b) ? a : b;
    end
  endfunction

  function [7:0] be_byte;
    input [31:0] word;
    input [1:0]  lane;
    begin
      case (lane)
        2'h0: be_byte = word[31:24];
        2'h1: be_byte = word[23:16];
        2'h2: be_byte = word[15:8];
        default: be_byte = word[7:0];
      endcase
    end
  endfunction

  // Only unit zero exists, so every byte but the list length is zero.
  function [7:0] unit_list_byte;
    input [31:0] idx;
    begin
      if (idx == `UNIT_LEN_POS) begin
        unit_list_byte = `UNIT_LIST_LEN;
      end else begin
        unit_list_byte = 8'h00;
      end
    end
  endfunction

  // ****************************************
  // Store readiness synchroniser
  // ****************************************
  // Readiness comes from another domain, so it is filtered before use.
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      store_s1 <= 1'b0;
      store_s2 <= 1'b0;
      store_s3 <= 1'b0;
      store_ok <= 1'b0;
    end else begin
      store_s1 <= store_ready_in;
      store_s2 <= store_s1;
      store_s3 <= store_s2;
      if (store_s2 == store_s3) begin
        store_ok <= store_s3;
      end
    end
  end

  // ****************************************
  // Parameter data byte selection
  // ****************************************
  always @* begin
    next_byte = 8'h00;
    if (is_units) begin
      next_byte = unit_list_byte(pos); // RQ14 RQ15
    end else if (pos < `HDR_BYTES) begin
      next_byte = be_byte(id_len, pos[1:0]); // RQ4
    end else begin
      next_byte = id_byte_in; // RQ8
    end
  end

  // ****************************************
  // Buffer toward the receiver
  // ****************************************
  // The sequencer runs on while the output stage holds a word, so a stall by
  // the receiver never drops a byte.
  skid_buffer #(
    .WIDTH (9)
  ) u_buf (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .s_data_in   ({(pos + 32'h1 == xfer_len), next_byte}),
    .s_valid_in  (state == S_SEND),
    .s_ready_out (buf_ready),
    .m_data_out  (buf_word),
    .m_valid_out (buf_valid),
    .m_ready_in  (data_ready_in | ~data_valid_out)
  );

  // ****************************************
  // Command sequencer
  // ****************************************
  always @(posedge clock_in or negedge rst_n_in) begin : seq
    integer i;
    if (!rst_n_in) begin
      state          <= S_CDB;
      cdb_idx        <= {`CDB_IDX_W{1'b0}};
      for (i = 0; i < `CDB_BYTES; i = i + 1) begin
        cdb[i] <= 8'h00;
      end
      is_units       <= 1'b0;
      xfer_len       <= 32'h0;
      pos            <= 32'h0;
      id_len         <= 32'h0;
      cdb_ready_out  <= 1'b0;
      id_addr_out    <= {ID_IDX_W{1'b0}};
      done_out       <= 1'b0;
      pend_status    <= `STATUS_GOOD;
      pend_key       <= `KEY_NONE;
      pend_asc       <= `ASC_NONE;
      pend_ascq      <= `ASC_NONE;
    end else begin
      done_out      <= 1'b0;
      cdb_ready_out <= (state == S_CDB);
      case (state)
        S_CDB: begin
          if (cdb_valid_in && cdb_ready_out) begin
            cdb[cdb_idx] <= cdb_byte_in;
            if (cdb_idx == `CDB_LAST) begin
              cdb_idx       <= {`CDB_IDX_W{1'b0}};
              cdb_ready_out <= 1'b0;
              state         <= S_DEC;
            end else begin
              cdb_idx <= cdb_idx + 1'b1;
            end
          end
        end
        S_DEC: begin
          pos            <= 32'h0;
          id_len         <= id_len_in; // RQ6
          pend_status    <= `STATUS_CHECK;
          pend_key       <= `KEY_ILLEGAL;
          pend_asc       <= `ASC_INVALID_CDB;
          pend_ascq      <= `ASC_NONE;
          state          <= S_DONE;
          if (is_units_cmd) begin
            // No reservation input exists, so the list is never blocked.
            is_units <= 1'b1; // RQ11
            // A short allocation keeps the invalid field answer set above.
            if (alloc_len >= `UNIT_LIST_BYTES) begin // RQ12
              xfer_len <= `UNIT_LIST_BYTES; // RQ13
              state    <= S_SEND;
            end
          end else if (is_id_cmd) begin
            is_units <= 1'b0;
            if (lun_nonzero) begin
              state <= S_DONE; // RQ2
            end else if (!store_ok) begin
              pend_key  <= `KEY_NOT_READY; // RQ9
              pend_asc  <= `ASC_NOT_READY;
              pend_ascq <= `ASCQ_NOT_READY;
            end else begin
              // The identifier data is capped at ID_MAX bytes, while the length
              // field still carries the full stored length.
              xfer_len <= min32(alloc_len,
                                `HDR_BYTES + min32(id_len_in, ID_MAX)); // RQ3 RQ5
              state    <= (alloc_len == 32'h0) ? S_WAIT : S_SEND;
            end
          end
        end
        S_SEND: begin
          id_addr_out <= id_index[ID_IDX_W-1:0]; // RQ7
          if (buf_ready) begin
            if (pos + 32'h1 == xfer_len) begin
              state <= S_WAIT;
            end
            pos <= pos + 32'h1;
          end
        end
        S_WAIT: begin
          if (!buf_valid && !data_valid_out) begin
            pend_status <= `STATUS_GOOD; // RQ16
            pend_key    <= `KEY_NONE;
            pend_asc    <= `ASC_NONE;
            pend_ascq   <= `ASC_NONE;
            state       <= S_DONE;
          end
        end
        S_DONE: begin
          done_out <= 1'b1;
          state    <= S_CDB;
        end
        default: begin
          state <= S_CDB;
        end
      endcase
    end
  end

  // ****************************************
  // Completion status
  // ****************************************
  // The answer reaches the outputs only together with done_out, so the host
  // finds the previous command's status standing until the next completion.
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out    <= `STATUS_GOOD;
      sense_key_out <= `KEY_NONE;
      asc_out       <= `ASC_NONE;
      ascq_out      <= `ASC_NONE;
    end else if (state == S_DONE) begin
      status_out    <= pend_status; // RQ16
      sense_key_out <= pend_key;
      asc_out       <= pend_asc;
      ascq_out      <= pend_ascq;
    end
  end

  // ****************************************
  // Output register stage
  // ****************************************
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_out       <= 8'h00;
      data_last_out  <= 1'b0;
      data_valid_out <= 1'b0;
    end else if (data_ready_in || !data_valid_out) begin
      data_valid_out <= buf_valid;
      data_out       <= buf_word[7:0];
      data_last_out  <= buf_word[8];
    end
  end
endmodule // report_cmd

// >>> test/report_cmd_checker.sv
`timescale 1ns/1ps
`include "report_consts.vh"
// ****************************************
// Checker on the command block ports
// ****************************************
module report_cmd_checker #(
  parameter ID_MAX   = 64,
  parameter ID_IDX_W = 6
) (
  input wire logic                clock_in, rst_n_in, cdb_valid_in, cdb_ready_out,
  input wire logic [7:0]          cdb_byte_in, id_byte_in, data_out, status_out, asc_out,
  input wire logic [7:0]          ascq_out,
  input wire logic [3:0]          sense_key_out,
  input wire logic                store_ready_in, data_last_out, data_valid_out,
  input wire logic                data_ready_in, done_out,
  input wire logic [31:0]         id_len_in,
  input wire logic [ID_IDX_W-1:0] id_addr_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  done_pulse_a: assert property (done_out |=> !done_out) else $error("done longer than one cycle");
  data_hold_a: assert property (data_valid_out && !data_ready_in |=> data_valid_out &&
    $stable(data_out) && $stable(data_last_out)) else $error("data word dropped in stall");
  status_hold_a: assert property (!done_out |-> $stable(status_out) && $stable(asc_out))
    else $error("status moved between completions");
  good_sense_a: assert property (done_out && status_out == `STATUS_GOOD |->
    sense_key_out == `KEY_NONE && asc_out == `ASC_NONE) else $error("sense on good");
  check_key_a: assert property (done_out && status_out == `STATUS_CHECK |->
    sense_key_out inside {`KEY_NOT_READY, `KEY_ILLEGAL}) else $error("bad sense key");
  illegal_asc_a: assert property (done_out && sense_key_out == `KEY_ILLEGAL |->
    asc_out == `ASC_INVALID_CDB) else $error("wrong code for illegal");
  not_ready_a: assert property (done_out && sense_key_out == `KEY_NOT_READY |->
    asc_out == `ASC_NOT_READY && ascq_out == `ASCQ_NOT_READY) else $error("not ready code");
  last_done_a: assert property (data_valid_out && data_ready_in && data_last_out |->
    ##[1:16] done_out) else $error("no completion after last byte");
  cover property (done_out && status_out == `STATUS_GOOD);
  cover property (done_out && sense_key_out == `KEY_ILLEGAL);
  cover property (done_out && sense_key_out == `KEY_NOT_READY);
  cover property (data_valid_out && !data_ready_in);
endmodule // report_cmd_checker
bind report_cmd report_cmd_checker #(.ID_MAX(ID_MAX), .ID_IDX_W(ID_IDX_W)) i_report_cmd_checker (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .cdb_valid_in(cdb_valid_in),
  .cdb_ready_out(cdb_ready_out), .cdb_byte_in(cdb_byte_in), .id_byte_in(id_byte_in),
  .data_out(data_out), .status_out(status_out), .asc_out(asc_out), .ascq_out(ascq_out),
  .sense_key_out(sense_key_out), .store_ready_in(store_ready_in),
  .data_last_out(data_last_out), .data_valid_out(data_valid_out),
  .data_ready_in(data_ready_in), .done_out(done_out), .id_len_in(id_len_in),
  .id_addr_out(id_addr_out));

// >>> test/store_receiver_model.sv
`timescale 1ns/1ps
// ****************************************
// Identifier store and data receiver
// ****************************************
module store_receiver_model (
  input  wire logic       clock_in,    // System clock.
  input  wire logic [5:0] id_addr_in,  // Identifier byte index.
  input  wire logic       stall_in,    // Receiver stalls every other cycle.
  output logic      [7:0] id_byte_out, // Identifier byte.
  output logic            ready_out    // Receiver takes byte.
);
  // The store ignores the block reset, so content survives it.
  assign id_byte_out = {2'h0, id_addr_in} ^ 8'h5a;
  initial ready_out = 1'b1;
  always @(negedge clock_in) begin
    ready_out <= stall_in ? !ready_out : 1'b1;
  end
endmodule // store_receiver_model

// >>> test/report_cmd_bench.sv
`timescale 1ns/1ps
`include "report_consts.vh"
module report_cmd_bench;
  logic clock_in, rst_n_in, cdb_valid, store_ready, data_ready, stall, data_last, data_valid;
  logic done;
  logic [7:0]  cdb_byte, id_byte, data, status, asc, ascq;
  logic [3:0]  key;
  logic [5:0]  id_addr;
  logic [31:0] id_len;
  logic        cdb_ready;
  int          n_errors, cmp_count;
  report_cmd #(.ID_MAX(64), .ID_IDX_W(6)) i_report_cmd (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .cdb_byte_in(cdb_byte),
    .cdb_valid_in(cdb_valid), .cdb_ready_out(cdb_ready), .store_ready_in(store_ready),
    .id_len_in(id_len), .id_addr_out(id_addr), .id_byte_in(id_byte), .data_out(data),
    .data_last_out(data_last), .data_valid_out(data_valid), .data_ready_in(data_ready),
    .done_out(done), .status_out(status), .sense_key_out(key), .asc_out(asc),
    .ascq_out(ascq));
  store_receiver_model i_store_receiver_model (.clock_in(clock_in), .id_addr_in(id_addr),
    .stall_in(stall), .id_byte_out(id_byte), .ready_out(data_ready));
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = !clock_in;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset;
    rst_n_in = 1'b0;
    repeat (3) @(negedge clock_in);
    rst_n_in = 1'b1;
    @(negedge clock_in);
  endtask
  // Sends a whole descriptor, then checks every data byte, the count and the ending status.
  task automatic run(input logic [7:0] op, sa, input logic [15:0] lun, input logic [31:0] alloc,
                     input int exp_n, input logic [27:0] exp_st);
    logic [7:0] b [12];
    logic [7:0] e;
    int n, k;
    b = '{op, sa, 8'h00, 8'h00, lun[15:8], lun[7:0], alloc[31:24], alloc[23:16], alloc[15:8],
          alloc[7:0], 8'h00, 8'h00};
    for (int i = 0; i < 12; i++) begin
      cdb_byte = b[i];
      cdb_valid = 1'b1;
      k = 0;
      while (cdb_ready !== 1'b1 && k < 100) begin
        @(negedge clock_in);
        k++;
      end
      @(negedge clock_in);
    end
    cdb_valid = 1'b0;
    n = 0;
    k = 0;
    // The receiver moves its ready at the falling edge, so both sides are looked at
    // a little later, when they hold what the next rising edge will take.
    while (done !== 1'b1 && k < 2000) begin
      @(negedge clock_in);
      #1;
      if (data_valid === 1'b1 && data_ready === 1'b1) begin
        if (op == `OP_REPORT_UNITS) e = (n == 3) ? `UNIT_LIST_LEN : 8'h00;
        else e = (n < 4) ? id_len[8*(3-n) +: 8] : (8'(n - 4) ^ 8'h5a);
        cmp(data, e);
        cmp(data_last, n + 1 == exp_n);
        n++;
      end
      k++;
    end
    cmp(done, 1'b1);
    cmp(n, exp_n);
    cmp({status, key, asc, ascq}, exp_st);
    @(negedge clock_in);
  endtask
  localparam logic [27:0] GOOD = {`STATUS_GOOD, `KEY_NONE, `ASC_NONE, `ASC_NONE};
  localparam logic [27:0] ILL = {`STATUS_CHECK, `KEY_ILLEGAL, `ASC_INVALID_CDB, `ASC_NONE};
  localparam logic [27:0] NRDY = {`STATUS_CHECK, `KEY_NOT_READY, `ASC_NOT_READY,
                                  `ASCQ_NOT_READY};
  task automatic id_scenarios;
    run(`OP_REPORT_ID, 8'h05, 16'h0000, 32'd64, 4, GOOD);
    run(`OP_REPORT_ID, 8'h05, 16'h0000, 32'd0, 0, GOOD);
    id_len = 32'd5;
    run(`OP_REPORT_ID, 8'he5, 16'h0000, 32'd64, 9, GOOD);
    id_len = 32'd20;
    stall = 1'b1;
    run(`OP_REPORT_ID, 8'h05, 16'h0000, 32'd6, 6, GOOD);
    stall = 1'b0;
    run(`OP_REPORT_ID, 8'h05, 16'h0100, 32'd64, 0, ILL);
    run(`OP_REPORT_ID, 8'h0c, 16'h0000, 32'd64, 0, ILL);
    run(8'h5b, 8'h05, 16'h0000, 32'd64, 0, ILL);
    id_len = 32'd100;
    run(`OP_REPORT_ID, 8'h05, 16'h0000, 32'd200, 68, GOOD);
  endtask
  task automatic retain_scenario;
    id_len = 32'd7;
    do_reset();
    run(`OP_REPORT_ID, 8'h05, 16'h0000, 32'd64, 11, GOOD);
    run(`OP_REPORT_ID, 8'h05, 16'h0000, 32'd64, 11, GOOD);
  endtask
  task automatic not_ready_scenario;
    store_ready = 1'b0;
    repeat (8) @(negedge clock_in);
    run(`OP_REPORT_ID, 8'h05, 16'h0000, 32'd64, 0, NRDY);
    store_ready = 1'b1;
    repeat (8) @(negedge clock_in);
  endtask
  task automatic unit_scenarios;
    run(`OP_REPORT_UNITS, 8'h00, 16'h0000, 32'd16, 16, GOOD);
    run(`OP_REPORT_UNITS, 8'h00, 16'h0000, 32'd15, 0, ILL);
    stall = 1'b1;
    run(`OP_REPORT_UNITS, 8'h00, 16'h0000, 32'h0001_0000, 16, GOOD);
    stall = 1'b0;
  endtask
  initial begin
    n_errors = 0;
    cmp_count = 0;
    cdb_valid = 1'b0;
    cdb_byte = 8'h00;
    store_ready = 1'b1;
    stall = 1'b0;
    id_len = 32'd0;
    do_reset();
    repeat (8) @(negedge clock_in);
    id_scenarios();
    not_ready_scenario();
    unit_scenarios();
    retain_scenario();
    final_report();
  end
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule // report_cmd_bench
